/* design/sffs_pkg.sv */
package sffs_pkg;
    // Fault flag positions within the per-channel fault word
    localparam int FLT_SHORT = 0;
    localparam int FLT_OVERCUR = 1;
    localparam int FLT_HOT = 2;
    localparam int FLT_OPENLOAD = 3;
    localparam int FLT_SUPSHORT = 4;
    localparam int FLT_W = 5;
    localparam logic [FLT_W-1:0] FLT_RESET = 5'h00;
    // Supply condition bundle from the analog comparators
    typedef struct packed {
        logic pwrNormal;
        logic pwrBelowUv;
        logic pwrBelowExt;
        logic pwrOver;
        logic pwrOverRelease;
        logic logicFail;
        logic bothPor;
        logic sysGndLoss;
        logic devGndHigh;
    } sffs_supply_s;
    localparam int SUP_W = 9;
endpackage : sffs_pkg

/* design/supply_fault_failsafe_supervisor.sv */
`timescale 1ns/1ns
// Behaviour
// - Registers and flags hold while supply sits in extended range with logic supply good.
// - Below extended floor short and overcurrent still switch off but set no flag; overtemperature report deferred until above undervoltage.
// - Outputs stay on above normal limit only when overvoltage_disable set.
// - Logic-supply fail with normal power, or both supplies at POR, clear faults.
// - A fault flag clears on status read only after cause gone and delatched.
// - Short, overcurrent, overtemperature, undervoltage switch channel off at once, slew ignored.
// - Load ground loss keeps channel state and flags openload.
// - System ground loss switches channels off.
// - Device ground high stops SPI and enters fail-safe; low shift runs normally.
// - Logic supply fail with enable set enters fail-safe and resets registers.
// - In fail-safe, direct inputs drive channels when power supply normal.
// - During logic supply loss faults still show on active-low fault pin.
// - Without logic supply serial data output is not driven.
// - Logic supply loss with enable clear stays out of fail-safe, so channels follow SPI registers; spiEnable still drops.
// - Short-circuit pulls fault pin low and sets its fault bit.
// - Overvoltage flag clears on status read once below release level.
module sffs_supervisor #(
    parameter int CH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Analog supply and ground conditions
    input wire logic [sffs_pkg::SUP_W-1:0] supplyIn,
    input wire logic [CH-1:0] loadGndLoss,
    // Per-channel fault causes from the protection circuits
    input wire logic [CH-1:0] shortCause,
    input wire logic [CH-1:0] overcurrentCause,
    input wire logic [CH-1:0] overtempCause,
    input wire logic [CH-1:0] osCause,
    input wire logic [CH-1:0] olCause,
    // Control from the SPI register file
    input wire logic overvoltageDisable,
    input wire logic logicFailEnable,
    input wire logic [CH-1:0] spiChannelOn,
    input wire logic [CH-1:0] delatch,
    input wire logic statusRead,
    input wire logic spiSdoData,
    // Direct input pins
    input wire logic [CH-1:0] directIn,
    // Outputs
    output logic [CH-1:0] outputChannel,
    output logic [CH*sffs_pkg::FLT_W-1:0] faultFlags,
    output logic overvoltageFault,
    output logic undervoltageFault,
    output logic failSafe,
    output logic registerClear,
    output logic spiEnable,
    output logic sdoData,
    output logic sdoOe,
    output logic fault_status_n
);
    // Two-stage synchronisers for all asynchronous inputs
    localparam int SW = sffs_pkg::SUP_W + 7 * CH;
    logic [SW-1:0] syncA_reg;
    logic [SW-1:0] syncB_reg;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end
        else
        begin
            syncA_reg <= {supplyIn, loadGndLoss, shortCause, overcurrentCause, overtempCause,
                osCause, olCause, directIn};
            syncB_reg <= syncA_reg;
        end
    end
    sffs_pkg::sffs_supply_s sup;
    logic [CH-1:0] lgl, shortDet, overcurDet, hotDet, os, ol, din;
    assign {sup, lgl, shortDet, overcurDet, hotDet, os, ol, din} = syncB_reg;

    // Fault-clearing supply events and fail-safe entry
    logic supplyClear;
    logic failSafeNext;
    assign supplyClear = (sup.logicFail && sup.pwrNormal) || sup.bothPor;
    assign failSafeNext = (sup.logicFail && logicFailEnable) || sup.devGndHigh;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            failSafe <= 1'b0;
            registerClear <= 1'b0;
            spiEnable <= 1'b0;
            sdoOe <= 1'b0;
            sdoData <= 1'b0;
        end
        else
        begin
            failSafe <= failSafeNext;
            registerClear <= sup.logicFail && logicFailEnable;
            spiEnable <= !sup.devGndHigh && !sup.logicFail;
            sdoOe <= !sup.logicFail && !sup.devGndHigh;
            sdoData <= spiSdoData;
        end
    end

    // Sticky per-channel flags; set beats status-read clear in the same cycle, supply or register clear beats set
    logic [CH-1:0] chanLatched;
    genvar g;
    generate
        for (g = 0; g < CH; g++)
        begin : gChan
            logic [sffs_pkg::FLT_W-1:0] cause;
            logic [sffs_pkg::FLT_W-1:0] flags_reg;
            logic [sffs_pkg::FLT_W-1:0] flags_next;
            logic latched_reg;
            // Overtemperature report deferred while supply is under the undervoltage level
            assign cause = {os[g], ol[g] || lgl[g], hotDet[g] && !sup.pwrBelowUv,
                overcurDet[g] && !sup.pwrBelowExt,
                shortDet[g] && !sup.pwrBelowExt};
            always_comb
            begin
                flags_next = flags_reg;
                if (statusRead && latched_reg == 1'b0)
                    flags_next = flags_reg & cause;
                flags_next = flags_next | cause;
            end
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                    flags_reg <= sffs_pkg::FLT_RESET;
                else if (supplyClear || registerClear)
                    flags_reg <= sffs_pkg::FLT_RESET;
                else
                    flags_reg <= flags_next;
            end
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                    latched_reg <= 1'b0;
                else if (shortDet[g] || overcurDet[g] || hotDet[g] || sup.pwrBelowUv)
                    latched_reg <= 1'b1;
                else if (delatch[g] || supplyClear)
                    latched_reg <= 1'b0;
            end
            assign chanLatched[g] = latched_reg;
            assign faultFlags[g*sffs_pkg::FLT_W +: sffs_pkg::FLT_W] = flags_reg;

            // Immediate off on latchable fault, no slew ramp; system ground loss forces off
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                    outputChannel[g] <= 1'b0;
                else if (shortDet[g] || overcurDet[g] || hotDet[g] || sup.pwrBelowUv ||
                    latched_reg)
                    outputChannel[g] <= 1'b0;
                else if (sup.sysGndLoss)
                    outputChannel[g] <= 1'b0;
                else if (sup.pwrOver && !overvoltageDisable)
                    outputChannel[g] <= 1'b0;
                else if (failSafeNext)
                    outputChannel[g] <= din[g] && sup.pwrNormal;
                else
                    outputChannel[g] <= spiChannelOn[g];
            end
        end
    endgenerate

    // Common supply flags
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            overvoltageFault <= 1'b0;
        else if (supplyClear || registerClear)
            overvoltageFault <= 1'b0;
        else if (sup.pwrOver)
            overvoltageFault <= 1'b1;
        else if (statusRead && sup.pwrOverRelease)
            overvoltageFault <= 1'b0;
    end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            undervoltageFault <= 1'b0;
        else if (supplyClear || registerClear)
            undervoltageFault <= 1'b0;
        else if (sup.pwrBelowUv)
            undervoltageFault <= 1'b1;
        else if (statusRead && ~|chanLatched)
            undervoltageFault <= 1'b0;
    end

    // Fault pin reflects live faults even without logic supply
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            fault_status_n <= 1'b1;
        else
            fault_status_n <= !(|shortDet || |overcurDet || |hotDet || |os || |ol ||
                |chanLatched || (sup.pwrOver && !overvoltageDisable) ||
                sup.pwrBelowUv);
    end

    // Assertions
    property p_fastoff;
        @(posedge clk) disable iff (reset) $rose(shortDet[CH-1]) |=> !outputChannel[CH-1];
    endproperty
    a_fastoff: assert property (p_fastoff) else $error("channel not off after short");
    property p_sysgnd;
        @(posedge clk) disable iff (reset) sup.sysGndLoss |=> outputChannel == '0;
    endproperty
    a_sysgnd: assert property (p_sysgnd) else $error("channels on at ground loss");
    property p_sdo;
        @(posedge clk) disable iff (reset) sup.logicFail |=> !sdoOe;
    endproperty
    a_sdo: assert property (p_sdo) else $error("serial out driven without logic supply");
    property p_gndhigh;
        @(posedge clk) disable iff (reset) sup.devGndHigh |=> failSafe && !spiEnable;
    endproperty
    a_gndhigh: assert property (p_gndhigh) else $error("no fail-safe on ground high");
    property p_regclr;
        @(posedge clk) disable iff (reset) registerClear |=> faultFlags == '0 && !overvoltageFault;
    endproperty
    a_regclr: assert property (p_regclr) else $error("registers not reset");
    property p_nofs;
        @(posedge clk) disable iff (reset) (sup.logicFail && !logicFailEnable && !sup.devGndHigh)
            |=> !failSafe;
    endproperty
    a_nofs: assert property (p_nofs) else $error("fail-safe entered with enable clear");
    property p_scpin;
        @(posedge clk) disable iff (reset) |shortDet |=> !fault_status_n;
    endproperty
    a_scpin: assert property (p_scpin) else $error("fault pin not low on short");
    property p_ov;
        @(posedge clk) disable iff (reset) (sup.pwrOver && !overvoltageDisable) |=>
            outputChannel == '0;
    endproperty
    a_ov: assert property (p_ov) else $error("output on during overvoltage");
endmodule : sffs_supervisor

/* verification/sffs_host_model.sv */
`timescale 1ns/1ns
module sffs_host_model #(
    parameter int CH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Requests from the bench
    input wire logic readReq,
    input wire logic overvoltDisReq,
    input wire logic [CH-1:0] delatchReq,
    // Control toward the supervisor
    output logic statusRead,
    output logic overvoltageDisable,
    output logic [CH-1:0] delatch
);
    // Registered so every control change lands just after an edge
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            statusRead <= 1'b0;
            overvoltageDisable <= 1'b0;
            delatch <= '0;
        end
        else
        begin
            statusRead <= readReq;
            overvoltageDisable <= overvoltDisReq;
            delatch <= delatchReq;
        end
    end
endmodule : sffs_host_model

/* verification/test_supply_fault_failsafe_supervisor.sv */
`timescale 1ns/1ns
module test_supply_fault_failsafe_supervisor;
    localparam int CH = 2;
    logic clk = 1'b0;
    logic reset = 1'b1;
    localparam sffs_pkg::sffs_supply_s SUP_IDLE = '{pwrNormal: 1'b1, default: 1'b0};
    sffs_pkg::sffs_supply_s sup;
    logic [CH-1:0] lgl, shortIn, overcurIn, hotIn, os, ol, chOn, din, dlReq, dl, outCh;
    logic overvoltDis, overvoltDisReq, lfEn, rdReq, rd, sdoIn;
    logic overvoltFlag, undervoltFlag, fs, rClr, spiEn, sdo, sdoOe, fltN;
    logic [CH*sffs_pkg::FLT_W-1:0] flags;
    int n_mismatch = 0;
    int tests_run = 0;
    always #4 clk = ~clk;
    sffs_host_model #(.CH(CH)) host_u (.clk(clk), .reset(reset), .readReq(rdReq),
        .overvoltDisReq(overvoltDisReq), .delatchReq(dlReq), .statusRead(rd),
        .overvoltageDisable(overvoltDis), .delatch(dl));
    sffs_supervisor #(.CH(CH)) dut_u (.clk(clk), .reset(reset), .supplyIn(sup),
        .loadGndLoss(lgl), .shortCause(shortIn), .overcurrentCause(overcurIn),
        .overtempCause(hotIn), .osCause(os), .olCause(ol), .overvoltageDisable(overvoltDis),
        .logicFailEnable(lfEn), .spiChannelOn(chOn), .delatch(dl), .statusRead(rd),
        .spiSdoData(sdoIn), .directIn(din), .outputChannel(outCh), .faultFlags(flags),
        .overvoltageFault(overvoltFlag), .undervoltageFault(undervoltFlag), .failSafe(fs),
        .registerClear(rClr), .spiEnable(spiEn), .sdoData(sdo), .sdoOe(sdoOe),
        .fault_status_n(fltN));
    function automatic logic [15:0] flagAt(input int ch, input int pos);
        return 16'h0001 << (ch * sffs_pkg::FLT_W + pos);
    endfunction : flagAt
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask : settle
    task automatic idle();
        sup <= SUP_IDLE;
        {lgl, shortIn, overcurIn, hotIn, os, ol, din, dlReq} <= '0;
        {overvoltDisReq, lfEn, rdReq, sdoIn} <= '0;
        chOn <= 2'h3;
    endtask : idle
    task automatic doReset();
        @(posedge clk);
        reset <= 1'b1;
        idle();
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        settle();
    endtask : doReset
    task automatic pulse(input logic r, input logic [CH-1:0] d);
        @(posedge clk);
        rdReq <= r;
        dlReq <= d;
        @(posedge clk);
        rdReq <= 1'b0;
        dlReq <= '0;
        settle();
    endtask : pulse
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        idle();
        void'($urandom(3789));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        settle();
        @(posedge clk);
        shortIn <= 2'h1;
        settle();
        chk(outCh, 16'h2);
        chk(flags, flagAt(0, sffs_pkg::FLT_SHORT));
        chk(fltN, 16'h0);
        pulse(1'b1, 2'h0);
        chk(flags, flagAt(0, sffs_pkg::FLT_SHORT));
        @(posedge clk);
        shortIn <= 2'h0;
        pulse(1'b1, 2'h0);
        chk(flags, flagAt(0, sffs_pkg::FLT_SHORT));
        pulse(1'b0, 2'h1);
        pulse(1'b1, 2'h0);
        chk(flags, 16'h0);
        @(posedge clk);
        lgl <= 2'h2;
        sdoIn <= 1'b1;
        settle();
        chk(outCh, 16'h3);
        chk(flags, flagAt(1, sffs_pkg::FLT_OPENLOAD));
        chk({sdoOe, sdo}, 16'h3);
        @(posedge clk);
        overcurIn <= 2'h2;
        settle();
        chk(outCh, 16'h1);
        chk(flags, flagAt(1, sffs_pkg::FLT_OPENLOAD) | flagAt(1, sffs_pkg::FLT_OVERCUR));
        doReset();
        @(posedge clk);
        sup.sysGndLoss <= 1'b1;
        settle();
        chk(outCh, 16'h0);
        doReset();
        @(posedge clk);
        os <= 2'h1;
        settle();
        @(posedge clk);
        os <= 2'h0;
        overvoltDisReq <= 1'b1;
        sup.pwrOver <= 1'b1;
        settle();
        chk(outCh, 16'h3);
        chk({overvoltFlag, fltN}, 16'h3);
        chk(flags, flagAt(0, sffs_pkg::FLT_SUPSHORT));
        @(posedge clk);
        overvoltDisReq <= 1'b0;
        settle();
        chk({outCh, fltN}, 16'h0);
        pulse(1'b1, 2'h0);
        chk(overvoltFlag, 16'h1);
        @(posedge clk);
        sup <= '{pwrNormal: 1'b1, pwrOverRelease: 1'b1, default: 1'b0};
        pulse(1'b1, 2'h0);
        chk(overvoltFlag, 16'h0);
        chk(outCh, 16'h3);
        doReset();
        @(posedge clk);
        shortIn <= 2'h2;
        settle();
        @(posedge clk);
        shortIn <= 2'h0;
        sup.logicFail <= 1'b1;
        settle();
        chk(flags, 16'h0);
        chk(fs, 16'h0);
        chk(outCh, 16'h3);
        doReset();
        @(posedge clk);
        sup <= '{pwrBelowUv: 1'b1, pwrBelowExt: 1'b1, default: 1'b0};
        hotIn <= 2'h1;
        settle();
        chk(outCh, 16'h0);
        chk(flags, 16'h0);
        chk(undervoltFlag, 16'h1);
        @(posedge clk);
        sup <= SUP_IDLE;
        settle();
        chk(flags, flagAt(0, sffs_pkg::FLT_HOT));
        @(posedge clk);
        hotIn <= 2'h0;
        sup <= '{bothPor: 1'b1, default: 1'b0};
        settle();
        chk({undervoltFlag, flags}, 16'h0);
        doReset();
        @(posedge clk);
        lfEn <= 1'b1;
        sup.logicFail <= 1'b1;
        settle();
        chk({fs, rClr, sdoOe}, 16'h6);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            din <= CH'($urandom);
            settle();
            chk(outCh, din);
        end
        @(posedge clk);
        hotIn <= 2'h2;
        settle();
        chk(fltN, 16'h0);
        doReset();
        @(posedge clk);
        sup.devGndHigh <= 1'b1;
        settle();
        chk({fs, spiEn}, 16'h2);
        give_verdict();
    end
endmodule : test_supply_fault_failsafe_supervisor
